// [bench/io_mapped_watchdog_timer_checker.sv]
// port assertions for the watchdog timer
`timescale 1ns/1ps
module io_mapped_watchdog_timer_checker
  import wdt_pkg::*;
(
  // watched ports
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       clock_enable,
  input wire io_req_t    io_req,
  input wire logic [7:0] io_rdata,
  input wire logic       io_rvalid,
  input wire logic       timeout_supervisor_expired,
  input wire logic       timeout_supervisor_pin
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic on;
  logic armed;
  wire  w   = clock_enable && io_req.wr;
  wire  ex  = timeout_supervisor_expired;
  wire  pin = timeout_supervisor_pin;
  // mirror of pin routing and of a nonzero count, so expiry has a cause
  always_ff @(posedge clock)
  begin
    if (reset)
      {on, armed} <= 2'b00;
    else if (w && io_req.addr == 16'h0A47)
      on <= io_req.wdata == 8'h0C;
    else if (w && io_req.addr == 16'h0A66)
      armed <= io_req.wdata != 8'h00;
    else if (w && io_req.addr == 16'h0A67 && io_req.wdata[0])
      armed <= 1'b1;
  end
  a_read_answered: assert property (clock_enable && io_req.rd |=> io_rvalid)
    else $error("read not answered");
  a_rvalid_pulse: assert property (clock_enable && !io_req.rd |=> !io_rvalid)
    else $error("stray read valid");
  a_rdata_idle: assert property (!io_rvalid |-> io_rdata == 8'h00)
    else $error("read data not idle");
  a_pin_follows: assert property (pin == (ex && on))
    else $error("pin does not follow status");
  a_zero_no_expiry: assert property ($rose(ex) |-> armed || $past(armed))
    else $error("expiry without nonzero count");
  a_freeze_state: assert property (!clock_enable |=> $stable(ex) && $stable(io_rvalid))
    else $error("state moved while frozen");
endmodule

bind io_mapped_watchdog_timer io_mapped_watchdog_timer_checker i_chk
(
  .clock(clock), .reset(reset), .clock_enable(clock_enable), .io_req(io_req),
  .io_rdata(io_rdata), .io_rvalid(io_rvalid),
  .timeout_supervisor_expired(timeout_supervisor_expired),
  .timeout_supervisor_pin(timeout_supervisor_pin)
);

// [bench/tb_io_mapped_watchdog_timer.sv]
// self-checking bench for the watchdog timer
`timescale 1ns/1ps
module tb_io_mapped_watchdog_timer import wdt_pkg::*;;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic       ce    = 1'b1;
  io_req_t    q     = '0;
  logic [7:0] rdata;
  logic       rv, ex, pin;
  int         n_fail = 0;
  int         checks = 0;
  // short prescalers keep a minute at twelve cycles
  io_mapped_watchdog_timer #(.TICKS_PER_SEC(4), .SECS_PER_MIN(3)) i_dut
  (.clock(clock), .reset(reset), .clock_enable(ce), .io_req(q), .io_rdata(rdata),
   .io_rvalid(rv), .timeout_supervisor_expired(ex), .timeout_supervisor_pin(pin));
  initial forever #25 clock = ~clock;
  task automatic chk(string s, logic [8:0] g, logic [8:0] e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // one host cycle; a read judges the answer just after the taking edge
  task automatic io(logic [15:0] a, logic [7:0] d, logic r);
    @(posedge clock);
    q <= '{a, d, !r, r};
    @(posedge clock);
    q <= '0;
    if (r)
    begin
      #1;
      chk("read", {rv, rdata}, {1'b1, d});
    end
  endtask
  task automatic n(int c, logic e);
    repeat (c) @(posedge clock);
    #1;
    chk("expired", {8'h00, ex}, {8'h00, e});
  endtask
  task automatic t_regs;
    io(16'h0A66, 8'h00, 1);
    io(16'h0A67, 8'h00, 1);
    io(16'h0A65, 8'hFF, 0);
    io(16'h0A65, 8'h80, 1);
    io(16'h0A47, 8'h0C, 0);
    io(16'h0A47, 8'h0C, 1);
    io(16'h0A10, 8'h5A, 0);
    io(16'h0A10, 8'h00, 1);
    io(16'h0B66, 8'h00, 1);
    io(16'h0B66, 8'h33, 0);
    io(16'h0A66, 8'h00, 1);
  endtask
  task automatic t_sec;
    io(16'h0A66, 8'h02, 0);
    n(7, 0);
    n(1, 1);
    n(1, 1);
    chk("pin", {8'h00, pin}, 9'h001);
    io(16'h0A67, 8'h01, 1);
    io(16'h0A67, 8'h00, 0);
    n(0, 0);
    chk("pin", {8'h00, pin}, 9'h000);
  endtask
  task automatic t_min;
    io(16'h0A65, 8'h00, 0);
    io(16'h0A66, 8'h01, 0);
    n(11, 0);
    n(1, 1);
    io(16'h0A67, 8'h00, 0);
  endtask
  task automatic t_zero;
    io(16'h0A66, 8'hFF, 0);
    io(16'h0A66, 8'hFF, 1);
    io(16'h0A66, 8'h00, 0);
    ce <= 1'b0;
    repeat (3) @(posedge clock);
    ce <= 1'b1;
    n(40, 0);
    io(16'h0A66, 8'h00, 1);
  endtask
  // a low clock enable mid-count stretches the countdown by the frozen edges
  task automatic t_freeze;
    io(16'h0A65, 8'h80, 0);
    io(16'h0A66, 8'h01, 0);
    ce <= 1'b0;
    repeat (8) @(posedge clock);
    ce <= 1'b1;
    n(3, 0);
    n(1, 1);
    io(16'h0A67, 8'h00, 0);
  endtask
  task automatic report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    t_regs;
    t_sec;
    t_min;
    t_zero;
    t_freeze;
    report_and_stop;
  end
  // hang guard, far beyond the roughly 140 cycles needed
  initial
  begin
    #100000;
    n_fail++;
    report_and_stop;
  end
endmodule

// [hw/io_mapped_watchdog_timer.sv]
// i/o-mapped watchdog timer with byte registers behind a fixed base address
`timescale 1ns/1ps
`include "wdt_defs.svh"

// Overview of operation
// - registers decode as byte offsets from fixed i/o base a00h.
// - time-out count is an 8-bit register at offset 66h, 0 to 255.
// - a count of zero disables the watchdog; no expiry happens then.
// - units bit 7 at 65h selects minutes (0, default) or seconds (1).
// - status bit 0 reads 1 after a time-out until the host writes it 0, even while a reloaded count runs; read/write.
module io_mapped_watchdog_timer
  import wdt_pkg::*;
#(
  parameter int unsigned TICKS_PER_SEC = `WDT_TICKS_PER_SEC,
  parameter int unsigned SECS_PER_MIN  = `WDT_SECONDS_PER_MIN
)
(
  // clock and control
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       clock_enable,
  // host i/o port
  input  wire io_req_t    io_req,
  output logic [7:0]      io_rdata,
  output logic            io_rvalid,
  // watchdog outputs
  output logic            timeout_supervisor_expired,
  output logic            timeout_supervisor_pin
);

  // offset of an i/o address into the block, or 8'hff when outside it
  function automatic logic [7:0] block_offset(input logic [15:0] addr);
    logic [15:0] diff;
    diff = addr - `WDT_IO_BASE;
    if (diff[15:8] == 8'h00)
      block_offset = diff[7:0];
    else
      block_offset = 8'hFF;
  endfunction

  // programmed registers and live timer state
  logic [7:0]  pin_func;
  logic [7:0]  units;
  wdt_state_t  state;
  logic [31:0] sec_prescale;
  logic [7:0]  min_prescale;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        pin_out;

  logic [7:0]  next_pin_func;
  logic [7:0]  next_units;
  wdt_state_t  next_state;
  logic [31:0] next_sec_prescale;
  logic [7:0]  next_min_prescale;
  logic [7:0]  next_rdata;
  logic        next_rvalid;
  logic        next_pin_out;

  logic [7:0]  offset;
  logic        unit_tick;
  logic        sec_tick;
  logic        expire_now;

  // last prescaler counts, cut to the counter widths on purpose
  localparam logic [31:0] SEC_LAST = 32'(TICKS_PER_SEC - 1);
  localparam logic [7:0]  MIN_LAST = 8'(SECS_PER_MIN - 1);

  // register decode, prescalers and countdown
  always_comb
  begin
    offset = block_offset(io_req.addr);

    // programmed registers hold unless written
    next_pin_func = pin_func;
    next_units = units;
    next_state = state;

    // prescalers hold unless a tick, a units write or a count reload moves them
    next_sec_prescale = sec_prescale;
    next_min_prescale = min_prescale;

    // read path idles at zero between reads
    next_rdata = 8'h00;
    next_rvalid = io_req.rd;

    // strobes of this cycle
    sec_tick = 1'b0;
    unit_tick = 1'b0;
    expire_now = 1'b0;

    // prescalers only run while armed, so a fresh count gets a full first unit
    if (state.count != 8'h00)
    begin
      if (sec_prescale == SEC_LAST)
      begin
        next_sec_prescale = 32'h0000_0000;
        sec_tick = 1'b1;
      end
      else
        next_sec_prescale = sec_prescale + 32'h0000_0001;
    end

    if (sec_tick)
    begin
      if (units[`WDT_UNITS_BIT])
        unit_tick = 1'b1;
      else if (min_prescale == MIN_LAST)
      begin
        next_min_prescale = 8'h00;
        unit_tick = 1'b1;
      end
      else
        next_min_prescale = min_prescale + 8'h01;
    end

    // decrement and flag on reaching zero
    // a zero count never ticks, so never expires
    if (unit_tick && state.count != 8'h00)
    begin
      next_state.count = state.count - 8'h01;
      if (state.count == 8'h01)
      begin
        next_state.expired = 1'b1;
        expire_now = 1'b1;
      end
    end

    // host writes; a write never masks an expiry in the same cycle
    if (io_req.wr)
    begin
      case (offset)
        `WDT_OFS_PIN_FUNC:
        begin
          next_pin_func = io_req.wdata;
        end
        `WDT_OFS_UNITS:
        begin
          next_units = io_req.wdata & 8'h80; // low bits reserved, read zero
          next_sec_prescale = 32'h0000_0000;
          next_min_prescale = 8'h00;
        end
        // count load, reload restarts the unit
        `WDT_OFS_COUNT:
        begin
          next_state.count = io_req.wdata;
          next_sec_prescale = 32'h0000_0000;
          next_min_prescale = 8'h00;
        end
        `WDT_OFS_STATUS:
        begin
          next_state.expired = io_req.wdata[`WDT_STATUS_BIT] | expire_now;
        end
        default: ;
      endcase
    end

    // read data, unmapped offsets return zero
    if (io_req.rd)
    begin
      case (offset)
        `WDT_OFS_PIN_FUNC: next_rdata = pin_func;
        `WDT_OFS_UNITS:    next_rdata = units;
        `WDT_OFS_COUNT:    next_rdata = state.count;
        `WDT_OFS_STATUS:   next_rdata = {7'h00, state.expired};
        default:           next_rdata = 8'h00;
      endcase
    end

    // pin drives only when routed
    next_pin_out = next_state.expired && (next_pin_func == `WDT_PIN_FUNC_ON);
  end

  // state registers; reset wins over a low clock enable so a stall still clears
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      // host-programmed registers
      pin_func <= `WDT_RST_PIN_FUNC;
      units <= `WDT_RST_UNITS;

      // timer disarmed, status clear
      state.count <= `WDT_RST_COUNT;
      state.expired <= 1'b0;
      sec_prescale <= 32'h0000_0000;
      min_prescale <= 8'h00;

      // read answer and pin idle
      rdata <= 8'h00;
      rvalid <= 1'b0;
      pin_out <= 1'b0;
    end
    else if (clock_enable)
    begin
      // host-programmed registers
      pin_func <= next_pin_func;
      units <= next_units;

      // timer state and prescalers
      state <= next_state;
      sec_prescale <= next_sec_prescale;
      min_prescale <= next_min_prescale;

      // read answer and pin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      pin_out <= next_pin_out;
    end
  end

  // outputs straight from flops
  assign io_rdata = rdata;
  assign io_rvalid = rvalid;
  assign timeout_supervisor_expired = state.expired;
  assign timeout_supervisor_pin = pin_out;

endmodule

// [hw/wdt_defs.svh]
// offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

`define WDT_IO_BASE        16'h0A00
`define WDT_OFS_PIN_FUNC   8'h47
`define WDT_OFS_UNITS      8'h65
`define WDT_OFS_COUNT      8'h66
`define WDT_OFS_STATUS     8'h67
`define WDT_PIN_FUNC_ON    8'h0C
`define WDT_UNITS_BIT      7
`define WDT_STATUS_BIT     0
`define WDT_RST_PIN_FUNC   8'h00
`define WDT_RST_UNITS      8'h00
`define WDT_RST_COUNT      8'h00
`define WDT_CLOCK_NS       50
`define WDT_SECOND_NS      1000000000
`define WDT_SECONDS_PER_MIN 60
`define WDT_TICKS_PER_SEC  (`WDT_SECOND_NS / `WDT_CLOCK_NS)

`endif

// [hw/wdt_pkg.sv]
// types shared by the watchdog design
package wdt_pkg;

  // one host i/o cycle, presented for a single clock
  typedef struct packed
  {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } io_req_t;

  // current counting state visible to the host
  typedef struct packed
  {
    logic [7:0] count;
    logic       expired;
  } wdt_state_t;

endpackage
